// *** hw/tcp_map.svh ***
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
// Register byte offsets
`define TCP_OFS_MODE 4'h0
`define TCP_OFS_CTRL 4'h4
`define TCP_OFS_CMP 4'h8
`define TCP_OFS_STAT 4'hc
// Reset values
`define TCP_MODE_RST 16'h0000
`define TCP_CTRL_RST 16'h0000
`define TCP_CMP_RST 16'h0000
// Mode register fields (byte per channel)
`define TCP_MS3_LO 0
`define TCP_FEN_BIT 2
`define TCP_SEN_BIT 3
`define TCP_MS4_LO 8
// Control register fields
`define TCP_EN3_BIT 0
`define TCP_POL3_BIT 1
`define TCP_EN4_BIT 2
`define TCP_POL4_BIT 3
`define TCP_PROTECTION_LEVEL_LO 4
`define TCP_SPM_BIT 6
`define TCP_OCTL_LO 8
// Codes
`define TCP_PROTECTION_LEVEL_LOCK 2'b11
`define TCP_OC_PWM0 3'b110
`define TCP_OC_PWM1 3'b111
// Trigger to output latency, clock cycles
`define TCP_LAT_SLOW 5
`define TCP_LAT_FAST 3
// AXI responses
`define TCP_RESP_OKAY 2'b00
`define TCP_RESP_SLVERR 2'b10
`endif

// *** hw/tcp_pkg.sv ***
package tcp_pkg;
    // Channel function select
    typedef enum logic [1:0] {TCP_MS_OUT, TCP_MS_OWN, TCP_MS_NBR, TCP_MS_ITS}
        tcp_mode_t;
    // One byte of the mode register in input view
    typedef struct packed {
        logic [3:0] filt;
        logic [1:0] psc;
        tcp_mode_t mode;
    } tcp_in_cfg_t;
    // Per channel enable and polarity
    typedef struct packed {
        logic en;
        logic pol;
    } tcp_chan_ctl_t;
endpackage

// *** hw/tcp_chan_pair.sv ***
// Functional notes
// - Shadow enabled: compare value loads on update
// - Shadow bit locked at protection 11, output
// - Fast compare: trigger edge forces compare level
// - Trigger latency 5 cycles, 3 when fast
// - Mode selects output or one of three inputs
// - Mode field frozen while channel enabled
// - Filter changes after N agreeing samples
// - Filter code picks sample rate and N
// - Prescaler captures every 1, 2, 4, 8 edges
// - Prescaler counter cleared when channel disabled
// - Fourth channel same fields in upper byte
// - Polarity picks rising or falling capture edge
// - Codes 110, 111 are the two PWM modes
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tcp_map.svh"

// Digital input filter, one per channel
module tcp_in_filter
    import tcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] filt,
    input wire logic raw,
    output logic filt_out
);
    logic [4:0] div_q; // Sample rate divider
    logic [3:0] run_q; // Agreeing sample count
    logic [4:0] mask; // Divider mask from code
    logic [3:0] need; // Samples needed (N)
    logic sample; // Sample strobe

    // Rate and length table; the sampling clock equals aclk here
    always_comb
    begin
        unique case (filt)
            4'h0: {mask, need} = {5'h00, 4'h1};
            4'h1: {mask, need} = {5'h00, 4'h2};
            4'h2: {mask, need} = {5'h00, 4'h4};
            4'h3: {mask, need} = {5'h00, 4'h8};
            4'h4: {mask, need} = {5'h01, 4'h6};
            4'h5: {mask, need} = {5'h01, 4'h8};
            4'h6: {mask, need} = {5'h03, 4'h6};
            4'h7: {mask, need} = {5'h03, 4'h8};
            4'h8: {mask, need} = {5'h07, 4'h6};
            4'h9: {mask, need} = {5'h07, 4'h8};
            4'ha: {mask, need} = {5'h0f, 4'h5};
            4'hb: {mask, need} = {5'h0f, 4'h6};
            4'hc: {mask, need} = {5'h0f, 4'h8};
            4'hd: {mask, need} = {5'h1f, 4'h5};
            4'he: {mask, need} = {5'h1f, 4'h6};
            4'hf: {mask, need} = {5'h1f, 4'h8};
        endcase
    end
    assign sample = ((div_q & mask) == 5'h00);

    // Free running sample divider
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_q <= 5'h00;
        else if (ce)
            div_q <= div_q + 5'h01;
    end

    // Event counter: a glitch shorter than N samples restarts it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_q <= 4'h0;
            filt_out <= 1'b0;
        end
        else if (ce && sample)
        begin
            if (raw == filt_out)
                run_q <= 4'h0;
            else if (run_q + 4'h1 >= need)
            begin
                filt_out <= raw;
                run_q <= 4'h0;
            end
            else
                run_q <= run_q + 4'h1;
        end
    end

    // Output only ever moves to the level just sampled
    property p_flt_follow;
        @(posedge aclk) disable iff (!aresetn)
        (filt_out != $past(filt_out)) |-> (filt_out == $past(raw));
    endproperty
    a_flt_follow: assert property (p_flt_follow)
        else $error("filter output moved against input");

    // Filter off passes a new level in one cycle
    property p_flt_off;
        @(posedge aclk) disable iff (!aresetn)
        (ce && filt == 4'h0 && raw != filt_out) |=> (filt_out == $past(raw));
    endproperty
    a_flt_off: assert property (p_flt_off)
        else $error("unfiltered input not passed in one cycle");
endmodule

// Edge detector and capture prescaler, one per channel
module tcp_edge_psc
    import tcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic en,
    input wire logic pol,
    input wire logic sig,
    input wire logic [1:0] psc,
    output logic cap
);
    logic prev_q; // Last raw source level
    logic [2:0] cnt_q; // Edges seen since last capture
    logic [2:0] mask; // Edges per capture minus one
    logic lvl; // Polarity corrected input
    logic edge_hit; // Valid edge this cycle

    assign lvl = sig ^ pol;
    // Old level seen through the current polarity, so a polarity
    // write on a quiet line gives no false edge
    assign edge_hit = lvl && !(prev_q ^ pol);
    assign mask = (psc == 2'b00) ? 3'h0 : (psc == 2'b01) ? 3'h1 :
        (psc == 2'b10) ? 3'h3 : 3'h7;

    // Edge history
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_q <= 1'b0;
        else if (ce)
            prev_q <= sig;
    end

    // Divide valid edges; disabling restarts the count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 3'h0;
            cap <= 1'b0;
        end
        else if (ce)
        begin
            cap <= 1'b0;
            if (!en)
                cnt_q <= 3'h0;
            else if (edge_hit)
            begin
                if ((cnt_q & mask) == mask)
                begin
                    cap <= 1'b1;
                    cnt_q <= 3'h0;
                end
                else
                    cnt_q <= cnt_q + 3'h1;
            end
        end
    end

    property p_psc_clear;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !en) |=> (cnt_q == 3'h0);
    endproperty
    a_psc_clear: assert property (p_psc_clear)
        else $error("prescaler count kept while disabled");

    property p_psc_each;
        @(posedge aclk) disable iff (!aresetn)
        (ce && en && psc == 2'b00 && edge_hit) |=> cap;
    endproperty
    a_psc_each: assert property (p_psc_each)
        else $error("undivided edge gave no capture");

    c_psc_eight: cover property (@(posedge aclk) disable iff (!aresetn)
        (psc == 2'b11 && cap));
endmodule

// Mode and compare configuration for the channel pair
module tcp_chan_pair
    import tcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic third_pin,
    input wire logic fourth_pin,
    input wire logic internal_trigger_input,
    input wire logic trigger_edge,
    input wire logic update_event,
    input wire logic [15:0] counter_value,
    input wire logic count_down,
    output logic third_channel_output_reference,
    output logic third_capture,
    output logic fourth_capture,
    output logic [15:0] third_channel_compare_value
);
    logic [15:0] mode_q; // Channel pair mode register
    logic [15:0] ctrl_q; // Enable, polarity, protection, compare code
    logic [15:0] cmp_pre_q; // Compare value as written
    logic [3:0] aw_q; // Latched write address
    logic [31:0] wd_q; // Latched write data
    logic [3:0] ws_q; // Latched strobes
    logic aw_have_q; // Write address held
    logic w_have_q; // Write data held
    logic do_wr; // Both halves present
    logic [15:0] wmask; // Byte lanes to 16-bit mask
    logic [15:0] mode_d; // Mode after locks
    logic [3:0] tpipe_q; // Trigger edge delay line
    logic [31:0] rd_d; // Read mux
    logic rd_ok; // Read address mapped
    tcp_in_cfg_t cfg3; // Third channel input view
    tcp_in_cfg_t cfg4; // Fourth channel input view
    tcp_chan_ctl_t ctl3; // Third channel enable and polarity
    tcp_chan_ctl_t ctl4; // Fourth channel enable and polarity
    logic shadow_en; // Compare shadow stage on
    logic fast_en; // Fast compare on
    logic [2:0] oc_code; // Compare output control
    logic pwm_mode; // One of the two PWM codes
    logic trig_hit; // Delayed trigger acting as match
    logic cmp_lt; // Counter below compare
    logic cmp_gt; // Counter above compare
    logic flt3; // Third filtered input
    logic flt4; // Fourth filtered input
    logic sel3; // Third selected capture source
    logic sel4; // Fourth selected capture source

    assign cfg3 = mode_q[7:0];
    assign cfg4 = mode_q[15:8];
    assign ctl3 = {ctrl_q[`TCP_EN3_BIT], ctrl_q[`TCP_POL3_BIT]};
    assign ctl4 = {ctrl_q[`TCP_EN4_BIT], ctrl_q[`TCP_POL4_BIT]};
    assign shadow_en = mode_q[`TCP_SEN_BIT];
    assign fast_en = mode_q[`TCP_FEN_BIT];
    assign oc_code = ctrl_q[`TCP_OCTL_LO +: 3];
    assign pwm_mode = (oc_code == `TCP_OC_PWM0) || (oc_code == `TCP_OC_PWM1);

    // Write channel acceptance, either order; response after both
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign do_wr = aw_have_q && w_have_q;
    assign wmask = {{8{ws_q[1]}}, {8{ws_q[0]}}};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 4'h0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q == `TCP_OFS_STAT ||
                    aw_q[1:0] != 2'b00) ? `TCP_RESP_SLVERR : `TCP_RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Mode write with the enable and protection locks
    always_comb
    begin
        mode_d = (mode_q & ~wmask) | (wd_q[15:0] & wmask);
        if (ctl3.en)
            mode_d[`TCP_MS3_LO +: 2] = mode_q[`TCP_MS3_LO +: 2];
        if (ctl4.en)
            mode_d[`TCP_MS4_LO +: 2] = mode_q[`TCP_MS4_LO +: 2];
        if (ctrl_q[`TCP_PROTECTION_LEVEL_LO +: 2] == `TCP_PROTECTION_LEVEL_LOCK &&
            cfg3.mode == TCP_MS_OUT)
            mode_d[`TCP_SEN_BIT] = mode_q[`TCP_SEN_BIT];
    end

    // Register file updates
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= `TCP_MODE_RST;
            ctrl_q <= `TCP_CTRL_RST;
            cmp_pre_q <= `TCP_CMP_RST;
        end
        else if (ce && do_wr)
        begin
            if (aw_q == `TCP_OFS_MODE)
                mode_q <= mode_d;
            if (aw_q == `TCP_OFS_CTRL)
                ctrl_q <= (ctrl_q & ~wmask) | (wd_q[15:0] & wmask);
            if (aw_q == `TCP_OFS_CMP)
                cmp_pre_q <= (cmp_pre_q & ~wmask) | (wd_q[15:0] & wmask);
        end
    end

    // Active compare value: shadowed loads wait for update event
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            third_channel_compare_value <= `TCP_CMP_RST;
        else if (ce && (!shadow_en || update_event))
            third_channel_compare_value <= cmp_pre_q;
    end

    // Read path, one cycle answer
    always_comb
    begin
        rd_ok = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (s_axi_araddr)
            `TCP_OFS_MODE: rd_d = {16'h0000, mode_q};
            `TCP_OFS_CTRL: rd_d = {16'h0000, ctrl_q};
            `TCP_OFS_CMP: rd_d = {16'h0000, cmp_pre_q};
            `TCP_OFS_STAT: rd_d = {13'h0, flt4, flt3,
                third_channel_output_reference, third_channel_compare_value};
            default: rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Trigger delay line; fast compare taps it earlier
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tpipe_q <= 4'h0;
        else if (ce)
            tpipe_q <= {tpipe_q[2:0], trigger_edge};
    end
    assign trig_hit = pwm_mode && cfg3.mode == TCP_MS_OUT &&
        (fast_en ? tpipe_q[`TCP_LAT_FAST - 2] :
        tpipe_q[`TCP_LAT_SLOW - 2]);

    assign cmp_lt = counter_value < third_channel_compare_value;
    assign cmp_gt = counter_value > third_channel_compare_value;

    // Output reference; non PWM codes belong to another block
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            third_channel_output_reference <= 1'b0;
        else if (ce && trig_hit)
            third_channel_output_reference <= 1'b1;
        else if (ce && oc_code == `TCP_OC_PWM0)
            third_channel_output_reference <= count_down ? !cmp_gt :
                cmp_lt;
        else if (ce && oc_code == `TCP_OC_PWM1)
            third_channel_output_reference <= count_down ? cmp_gt :
                !cmp_lt;
    end

    // Input path: filters, source select, prescalers
    tcp_in_filter u_flt3 (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .filt(cfg3.filt), .raw(third_pin), .filt_out(flt3));
    tcp_in_filter u_flt4 (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .filt(cfg4.filt), .raw(fourth_pin), .filt_out(flt4));

    // Trigger mode assumes software chose a trigger source
    assign sel3 = (cfg3.mode == TCP_MS_OWN) ? flt3 :
        (cfg3.mode == TCP_MS_NBR) ? flt4 : internal_trigger_input;
    assign sel4 = (cfg4.mode == TCP_MS_OWN) ? flt4 :
        (cfg4.mode == TCP_MS_NBR) ? flt3 : internal_trigger_input;

    tcp_edge_psc u_psc3 (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .en(ctl3.en && cfg3.mode != TCP_MS_OUT), .pol(ctl3.pol),
        .sig(sel3), .psc(cfg3.psc), .cap(third_capture));
    tcp_edge_psc u_psc4 (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .en(ctl4.en && cfg4.mode != TCP_MS_OUT), .pol(ctl4.pol),
        .sig(sel4), .psc(cfg4.psc), .cap(fourth_capture));

    property p_shadow_hold;
        @(posedge aclk) disable iff (!aresetn)
        (shadow_en && !update_event) |=>
        $stable(third_channel_compare_value);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold)
        else $error("shadowed compare moved without update");

    property p_direct;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !shadow_en) |=> (third_channel_compare_value ==
        $past(cmp_pre_q));
    endproperty
    a_direct: assert property (p_direct)
        else $error("unshadowed compare not taken at once");

    property p_sen_lock;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_q[5:4] == 2'b11 && cfg3.mode == TCP_MS_OUT) |=>
        $stable(mode_q[3]);
    endproperty
    a_sen_lock: assert property (p_sen_lock)
        else $error("locked shadow bit changed");

    property p_mode_lock;
        @(posedge aclk) disable iff (!aresetn)
        ctl3.en |=> $stable(mode_q[1:0]);
    endproperty
    a_mode_lock: assert property (p_mode_lock)
        else $error("mode changed while channel enabled");

    property p_fast_lat;
        @(posedge aclk) disable iff (!aresetn)
        (trigger_edge && fast_en && pwm_mode && cfg3.mode == TCP_MS_OUT &&
        ce) ##1 ce[*3] |-> third_channel_output_reference;
    endproperty
    a_fast_lat: assert property (p_fast_lat)
        else $error("fast trigger not seen after three cycles");

    property p_slow_lat;
        @(posedge aclk) disable iff (!aresetn)
        (trigger_edge && !fast_en && pwm_mode && cfg3.mode == TCP_MS_OUT &&
        ce) ##1 (ce && !fast_en)[*5] |-> third_channel_output_reference;
    endproperty
    a_slow_lat: assert property (p_slow_lat)
        else $error("trigger not seen after five cycles");

    property p_sel_own;
        @(posedge aclk) disable iff (!aresetn)
        (cfg3.mode == TCP_MS_OWN) |-> (sel3 == flt3);
    endproperty
    a_sel_own: assert property (p_sel_own)
        else $error("own input not selected");

    property p_pwm0_up;
        @(posedge aclk) disable iff (!aresetn)
        (ce && oc_code == 3'b110 && !count_down && cmp_lt) |=>
        third_channel_output_reference;
    endproperty
    a_pwm0_up: assert property (p_pwm0_up)
        else $error("first PWM mode inactive below compare");

    c_wr: cover property (@(posedge aclk) disable iff (!aresetn)
        (do_wr && aw_q == 4'h0));
    c_upd: cover property (@(posedge aclk) disable iff (!aresetn)
        (shadow_en && update_event));
    c_cap3: cover property (@(posedge aclk) disable iff (!aresetn)
        third_capture);
endmodule

// *** tb/tcp_src_model.sv ***
`timescale 1ns/1ns
// Far side: capture pins and trigger sources
module tcp_src_model
(
    input wire logic aclk,
    output logic pin3,
    output logic pin4,
    output logic itrig,
    output logic tedge
);
    // Lines idle low
    initial
    begin
        {itrig, pin4, pin3} = 3'b000;
        tedge = 1'b0;
    end
    // Set lines, held until next call
    task automatic lines(input logic [2:0] s);
        @(posedge aclk);
        {itrig, pin4, pin3} <= s;
    endtask
    // Low time outlasts the filter, so each pulse ends settled
    task automatic pulses(input logic [2:0] s, input int n, input int hi);
        for (int k = 0; k < n; k++)
        begin
            lines(s);
            repeat (hi - 1) @(posedge aclk);
            lines(3'b000);
            repeat (hi + 3) @(posedge aclk);
        end
    endtask
    // One-cycle trigger edge
    task automatic fire();
        @(posedge aclk);
        tedge <= 1'b1;
        @(posedge aclk);
        tedge <= 1'b0;
    endtask
endmodule

// *** tb/tcp_chan_pair_tb.sv ***
`timescale 1ns/1ns
`include "tcp_map.svh"
// Bench for the channel pair
module tcp_chan_pair_tb;
    logic aclk = 1'b0, aresetn = 1'b0, upd = 1'b0, dn = 1'b0;
    logic aw_v = 1'b0, w_v = 1'b0, b_y = 1'b0, ar_v = 1'b0, r_y = 1'b0;
    logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
    logic [31:0] w_d = 32'h0, r_d;
    logic [15:0] cnt = 16'h0000, act;
    logic aw_r, w_r, b_v, ar_r, r_v, ref_o, cap3, cap4;
    logic pin3, pin4, itrig, tedge;
    logic [1:0] b_p, r_p;
    int fails = 0, total_checks = 0, n3 = 0, n4 = 0;
    // 100 MHz
    always #5 aclk = ~aclk;
    // Far side
    tcp_src_model src (.aclk(aclk), .pin3(pin3), .pin4(pin4),
        .itrig(itrig), .tedge(tedge));
    tcp_chan_pair DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_p), .s_axi_bvalid(b_v),
        .s_axi_bready(b_y), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p),
        .s_axi_rvalid(r_v), .s_axi_rready(r_y), .third_pin(pin3),
        .fourth_pin(pin4), .internal_trigger_input(itrig),
        .trigger_edge(tedge), .update_event(upd), .counter_value(cnt),
        .count_down(dn), .third_channel_output_reference(ref_o),
        .third_capture(cap3), .fourth_capture(cap4),
        .third_channel_compare_value(act));
    // Capture pulse counters
    always @(posedge aclk)
    begin
        n3 += (cap3 === 1'b1);
        n4 += (cap4 === 1'b1);
    end
    // Verdict and stop
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask
    // One bus transfer; ready sampled 1 ns after an edge, acted on at next
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic [1:0] p);
        logic ta, tw, tb, tr, tq, busy;
        busy = 1'b1;
        q = 16'h0000;
        p = 2'h0;
        @(posedge aclk);
        aw_a <= a;
        ar_a <= a;
        w_d <= {16'h0000, d};
        {aw_v, w_v, b_y} <= {3{w}};
        {ar_v, r_y} <= {2{~w}};
        for (int i = 0; i < 50 && busy; i++)
        begin
            #1;
            ta = aw_v & aw_r;
            tw = w_v & w_r;
            tb = b_v & b_y;
            tr = ar_v & ar_r;
            tq = r_v & r_y;
            if (tq)
                q = r_d[15:0];
            if (tb | tq)
                p = tb ? b_p : r_p;
            @(posedge aclk);
            if (ta)
                aw_v <= 1'b0;
            if (tw)
                w_v <= 1'b0;
            if (tr)
                ar_v <= 1'b0;
            if (tb | tq)
                {b_y, r_y} <= 2'b00;
            busy = ~(tb | tq);
        end
        // Hung bus ends the run
        if (busy)
        begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d,
        input logic [1:0] e);
        logic [15:0] q;
        logic [1:0] p;
        bus(1'b1, a, d, q, p);
        chk({14'h0, p}, {14'h0, e});
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] q;
        logic [1:0] p;
        bus(1'b0, a, 16'h0000, q, p);
        chk(q, e);
        chk({14'h0, p}, 16'h0000);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // Reset values, refused writes
    task automatic t_regs();
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'h0000);
        wr(4'h2, 16'hffff, 2'h2);
        wr(4'hc, 16'hffff, 2'h2);
        rd(4'h0, 16'h0000);
    endtask
    // Compare value direct, then shadowed
    task automatic t_cmp();
        wr(4'h8, 16'h0010, 2'h0);
        tick(3);
        chk(act, 16'h0010);
        // Fast compare stays off, only shadow goes on
        wr(4'h0, 16'h0008, 2'h0);
        wr(4'h8, 16'h00a5, 2'h0);
        tick(3);
        chk(act, 16'h0010);
        @(posedge aclk);
        upd <= 1'b1;
        @(posedge aclk);
        upd <= 1'b0;
        tick(1);
        chk(act, 16'h00a5);
        rd(4'hc, 16'h00a5);
    endtask
    // Shadow bit and mode locks
    task automatic t_lock();
        wr(4'h4, 16'h0030, 2'h0);
        wr(4'h0, 16'h0000, 2'h0);
        rd(4'h0, 16'h0008);
        wr(4'h4, 16'h0001, 2'h0);
        wr(4'h0, 16'h0001, 2'h0);
        rd(4'h0, 16'h0000);
        wr(4'h4, 16'h0000, 2'h0);
    endtask
    // Trigger forces reference in both PWM codes
    task automatic t_trig();
        logic [15:0] on;
        for (int c = 6; c < 8; c++)
            for (int f = 0; f < 2; f++)
            begin
                on = (c == 6) ? 16'h0000 : 16'hffff;
                wr(4'h4, {5'h00, c[2:0], 8'h00}, 2'h0);
                wr(4'h0, {13'h0000, f[0], 2'b00}, 2'h0);
                @(posedge aclk);
                cnt <= on;
                tick(3);
                chk({15'h0, ref_o}, 16'h0001);
                // Down count at the compare value flips only code 111; code 110 stays high
                @(posedge aclk);
                {dn, cnt} <= {1'b1, 16'h00a5};
                tick(3);
                chk({15'h0, ref_o}, (c == 6) ? 16'h0001 : 16'h0000);
                @(posedge aclk);
                {dn, cnt} <= {1'b0, ~on};
                tick(3);
                chk({15'h0, ref_o}, 16'h0000);
                src.fire();
                tick((f ? `TCP_LAT_FAST : `TCP_LAT_SLOW) - 2);
                chk({15'h0, ref_o}, 16'h0000);
                tick(1);
                chk({15'h0, ref_o}, 16'h0001);
            end
    endtask
    // Edge divider, its clear, input polarity
    task automatic t_psc();
        for (int p = 0; p < 4; p++)
        begin
            wr(4'h4, 16'h0000, 2'h0);
            wr(4'h0, {4'h0, p[1:0], 2'b01, 4'h0, p[1:0], 2'b01}, 2'h0);
            wr(4'h4, 16'h0005, 2'h0);
            {n3, n4} = '0;
            src.pulses(3'b011, 8, 2);
            chk(n3[15:0], 16'h0008 >> p);
            chk(n4[15:0], 16'h0008 >> p);
        end
        src.pulses(3'b001, 4, 2);
        wr(4'h4, 16'h0000, 2'h0);
        wr(4'h4, 16'h0005, 2'h0);
        n3 = 0;
        src.pulses(3'b001, 4, 2);
        chk(n3[15:0], 16'h0000);
        wr(4'h4, 16'h0000, 2'h0);
        wr(4'h0, 16'h0001, 2'h0);
        wr(4'h4, 16'h0003, 2'h0);
        n3 = 0;
        src.lines(3'b001);
        tick(4);
        chk(n3[15:0], 16'h0000);
        src.lines(3'b000);
        tick(4);
        chk(n3[15:0], 16'h0001);
    endtask
    // Filter lengths, then trigger and neighbour sources
    task automatic t_filt();
        logic [3:0] fc [3] = '{4'h3, 4'h4, 4'hf};
        int g [3] = '{5, 9, 200};
        int l [3] = '{12, 20, 300};
        for (int k = 0; k < 3; k++)
        begin
            wr(4'h4, 16'h0000, 2'h0);
            wr(4'h0, {8'h00, fc[k], 4'h1}, 2'h0);
            wr(4'h4, 16'h0001, 2'h0);
            n3 = 0;
            src.pulses(3'b001, 1, g[k]);
            chk(n3[15:0], 16'h0000);
            src.pulses(3'b001, 1, l[k]);
            chk(n3[15:0], 16'h0001);
        end
        wr(4'h4, 16'h0000, 2'h0);
        wr(4'h0, 16'h0203, 2'h0);
        wr(4'h4, 16'h0005, 2'h0);
        {n3, n4} = '0;
        src.pulses(3'b100, 1, 3);
        chk({n4[7:0], n3[7:0]}, 16'h0001);
        src.pulses(3'b001, 1, 3);
        chk({n4[7:0], n3[7:0]}, 16'h0101);
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_cmp();
        t_lock();
        t_trig();
        t_psc();
        t_filt();
        end_of_test();
    end
endmodule
